// ### rtl/host_byte_port.sv
// Device end of the 8-bit asynchronous host port: data both ways, a
// status byte, a control byte and the host attention line.
// Assumes ref_clk is the master clock and the host keeps its timing.
// How it works
// - Select high with chip select and read low returns the status byte
// - Status bit 7 is 0 while an outbound byte waits; attention then high
// - Host read of data register sets bit 7 and drops attention
// - Status bit 6 is 0 when a new inbound byte can be taken
// - Master clock runs at four times the crystal frequency
// - Host bus and strobes are asynchronous and synchronised before use
// - Select low reaches data registers; high reads status, writes control
// - Attention high while data waits; cleared by a host data read
// - Only cycles with chip select low are answered; strobes active low
`timescale 1ns/1ns
`default_nettype none
module host_byte_port
    import host_port_pkg::*;
(
    input  wire logic       ref_clk,        // master clock, 4x crystal
    input  wire logic       sys_rst,        // synchronous reset, high
    input  wire logic       cs_n,           // host chip select, low
    input  wire logic       rd_n,           // host read strobe, low
    input  wire logic       wr_n,           // host write strobe, low
    input  wire logic       port_select,    // 0 data, 1 status/control
    input  wire logic [7:0] host_byte_in,   // data bus, input side
    output logic      [7:0] host_byte_out,  // data bus, output side
    output logic            host_byte_oe,   // high while driving the bus
    output logic            host_attention, // high while outbound waits
    input  wire logic       tx_load,        // pulse: load outbound byte
    input  wire logic [7:0] tx_byte,        // outbound byte
    output logic            tx_pending,     // outbound byte not yet read
    output logic      [7:0] rx_byte,        // last inbound byte
    output logic            rx_full,        // inbound byte held
    input  wire logic       rx_ack,         // pulse: inbound byte taken
    output logic      [7:0] ctrl_byte,      // last control byte
    output logic            ctrl_strobe,    // pulse: control byte written
    output logic            write_overrun   // sticky: writes too close
);
    host_pins_t raw_pins;
    host_pins_t pins;

    assign raw_pins = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                        port_select: port_select,
                        host_byte_bus: host_byte_in};

    // Bus data rides the same two stages as the strobes so it stays aligned
    pin_sync u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .pins_in  (raw_pins),
        .pins_out (pins)
    );

    // Previous synchronised pins for edge detection
    host_pins_t           prev_q;
    logic [7:0]           out_data_q;
    logic [7:0]           out_data_d;
    logic                 out_empty_q;
    logic                 out_empty_d;
    logic                 pend_q;
    logic [7:0]           in_data_q;
    logic [7:0]           in_data_d;
    logic                 in_full_q;
    logic                 in_full_d;
    logic [7:0]           ctrl_q;
    logic [7:0]           ctrl_d;
    logic                 ctrl_stb_q;
    logic [7:0]           rd_data_q;
    logic [7:0]           rd_data_d;
    logic                 oe_q;
    logic                 attn_q;
    logic [SPACING_W-1:0] gap_q;
    logic [SPACING_W-1:0] gap_d;
    logic                 overrun_q;
    logic                 overrun_d;
    logic [7:0]           wr_latch_q;
    logic [7:0]           wr_latch_d;

    // A host cycle is live only while chip select and its strobe are low
    function automatic logic strobe_on(input logic sel_n,
                                       input logic stb_n);
        return ~sel_n & ~stb_n;
    endfunction

    // Reads act at their start; writes act at their end, once the data
    // has had the whole strobe to cross the synchroniser.
    wire rd_act    = strobe_on(pins.cs_n, pins.rd_n);
    wire wr_act    = strobe_on(pins.cs_n, pins.wr_n);
    wire rd_was    = strobe_on(prev_q.cs_n, prev_q.rd_n);
    wire wr_was    = strobe_on(prev_q.cs_n, prev_q.wr_n);
    wire rd_start  = rd_act & ~rd_was;
    wire wr_end    = wr_was & ~wr_act;
    wire rd_is_dat = rd_start & (pins.port_select == SEL_DATA);
    wire wr_is_dat = wr_end & (prev_q.port_select == SEL_DATA);
    wire wr_is_ctl = wr_end & (prev_q.port_select == SEL_STATUS);

    wire [7:0] status_byte;
    assign status_byte = STATUS_RSVD
                       | (8'(out_empty_q) << ST_OUT_EMPTY)
                       | (8'(in_full_q) << ST_IN_FULL_N);

    // Read mux: status when select is high, outbound data when low
    assign rd_data_d = (pins.port_select == SEL_STATUS) ?
                       status_byte : out_data_q;

    // Outbound: device load sets pending; host data read clears it.
    // A load in the same cycle as the read wins, so no byte is lost.
    assign out_data_d  = tx_load ? tx_byte : out_data_q;
    assign out_empty_d = tx_load   ? 1'b0 :
                         rd_is_dat ? 1'b1 : out_empty_q;

    // Inbound: host data write fills; device ack frees. Fill wins.
    assign in_data_d = wr_is_dat ? wr_latch_q : in_data_q;
    assign in_full_d = wr_is_dat ? 1'b1 :
                       rx_ack    ? 1'b0 : in_full_q;

    assign ctrl_d = wr_is_ctl ? wr_latch_q : ctrl_q;

    // Track bus data while the write strobe is held low
    assign wr_latch_d = wr_act ? pins.host_byte_bus : wr_latch_q;

    // Write spacing watch: the host owns the spacing, the device only
    // flags a breach since a too-close byte may already be corrupted.
    // Restart at one so writes exactly the minimum apart stay legal
    assign gap_d     = wr_end ? SPACING_W'(1'b1) :
                       (gap_q == SPACING_MAX) ? gap_q : gap_q + 1'b1;
    assign overrun_d = overrun_q | (wr_end & (gap_q < SPACING_MAX));

    // Synchronised pins one cycle back, for strobe edge detection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_q <= PINS_IDLE;
        end else begin
            prev_q <= pins;
        end
    end

    // Outbound byte; pending has its own flop so the output is registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_data_q  <= DATA_RST;
            out_empty_q <= 1'b1;
            pend_q      <= 1'b0;
        end else begin
            out_data_q  <= out_data_d;
            out_empty_q <= out_empty_d;
            pend_q      <= ~out_empty_d;
        end
    end

    // Inbound holding register and its full flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_data_q <= DATA_RST;
            in_full_q <= 1'b0;
        end else begin
            in_data_q <= in_data_d;
            in_full_q <= in_full_d;
        end
    end

    // Control byte and its one-cycle strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q     <= CTRL_RST;
            ctrl_stb_q <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            ctrl_stb_q <= wr_is_ctl;
        end
    end

    // Write capture and spacing watch
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_latch_q <= DATA_RST;
            gap_q      <= SPACING_MAX;
            overrun_q  <= 1'b0;
        end else begin
            wr_latch_q <= wr_latch_d;
            gap_q      <= gap_d;
            overrun_q  <= overrun_d;
        end
    end

    // Bus drive: data is frozen at the start of the read so a clear of
    // the outbound flag during the strobe cannot change the byte seen.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_q <= DATA_RST;
        end else if (rd_start) begin
            rd_data_q <= rd_data_d;
        end
    end

    // Attention follows the next value so it rises together with pending
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            oe_q   <= 1'b0;
            attn_q <= 1'b0;
        end else begin
            oe_q   <= rd_act;
            attn_q <= ~out_empty_d;
        end
    end

    assign host_byte_out  = rd_data_q;
    assign host_byte_oe   = oe_q;
    assign host_attention = attn_q;
    assign tx_pending     = pend_q;
    assign rx_byte        = in_data_q;
    assign rx_full        = in_full_q;
    assign ctrl_byte      = ctrl_q;
    assign ctrl_strobe    = ctrl_stb_q;
    assign write_overrun  = overrun_q;

    // Master period is a quarter of the crystal period; the clock comes
    // from outside, so this only ties the constants together.
    localparam int unsigned XTAL_CHECK = XTAL_NS / XTAL_MULT;
endmodule
`default_nettype wire

// ### rtl/host_port_pkg.sv
// Constants and carrier types for the host byte port.
// Assumes a single master clock domain on the device side.
package host_port_pkg;

    // Master clock period and its tie to the crystal
    localparam int unsigned TCK_NS        = 20;
    localparam int unsigned XTAL_MULT     = 4;
    localparam int unsigned XTAL_NS       = TCK_NS * XTAL_MULT;
    // Least host write spacing, in master periods
    localparam int unsigned WRITE_CYC_TCK = 128;
    localparam int unsigned SPACING_W     = $clog2(WRITE_CYC_TCK + 1);
    localparam logic [SPACING_W-1:0] SPACING_MAX =
        SPACING_W'(WRITE_CYC_TCK);

    // Status byte layout
    localparam int unsigned ST_OUT_EMPTY  = 7;
    localparam int unsigned ST_IN_FULL_N  = 6;
    localparam logic [7:0]  STATUS_RSVD   = 8'h00;

    // Select line values
    localparam logic SEL_DATA   = 1'b0;
    localparam logic SEL_STATUS = 1'b1;

    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // Host pins as they arrive, all asynchronous to the master clock
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       port_select;
        logic [7:0] host_byte_bus;
    } host_pins_t;

    localparam int unsigned HOST_PINS_W = $bits(host_pins_t);
    localparam host_pins_t  PINS_IDLE   = '{cs_n: 1'b1, rd_n: 1'b1,
                                            wr_n: 1'b1, port_select: 1'b0,
                                            host_byte_bus: 8'h00};

endpackage

// ### rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous host pins.
// Assumes the pins change no faster than two master periods apart.
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import host_port_pkg::*;
(
    input  wire logic       ref_clk,  // master clock
    input  wire logic       sys_rst,  // synchronous reset, high
    input  wire host_pins_t pins_in,  // raw pins
    output host_pins_t      pins_out  // synchronised pins
);
    host_pins_t meta_q;
    host_pins_t sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= PINS_IDLE;
            sync_q <= PINS_IDLE;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
        end
    end

    assign pins_out = sync_q;
endmodule
`default_nettype wire

// ### bench/host_byte_port_monitor.sv
// Checker for the host byte port, bound to its top module.
// Assumes the host pins pass a two-flop synchroniser before use.
`timescale 1ns/1ns
`default_nettype none
module host_byte_port_monitor
    import host_port_pkg::*;
(
    input wire logic       ref_clk,        // master clock
    input wire logic       sys_rst,        // reset, high
    input wire logic       cs_n,           // chip select
    input wire logic       rd_n,           // read strobe
    input wire logic       wr_n,           // write strobe
    input wire logic       port_select,    // register choice
    input wire logic [7:0] host_byte_out,  // read data
    input wire logic       host_byte_oe,   // bus drive
    input wire logic       host_attention, // attention line
    input wire logic       tx_load,        // outbound load
    input wire logic       tx_pending,     // outbound waits
    input wire logic       rx_full,        // inbound held
    input wire logic       ctrl_strobe     // control pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Ranges allow for the synchroniser and edge detect latency
    sequence data_read;
        $fell(rd_n) ##0 (!cs_n && !rd_n && !port_select && !tx_load)[*6];
    endsequence
    sequence stat_read;
        (!cs_n && !rd_n && port_select)[*6];
    endsequence
    sequence stat_quiet;
        (!cs_n && !rd_n && port_select && !tx_load)[*6];
    endsequence
    a_attn_pending:
        assert property (stat_quiet |-> host_attention == !host_byte_out[7])
        else $error("attention differs from status bit");
    a_status_bus:
        assert property (stat_read |-> host_byte_oe && !host_byte_out[5:0])
        else $error("status byte not driven");
    a_read_clears:
        assert property (data_read |-> !tx_pending)
        else $error("data read left pending set");
    a_load_sets:
        assert property (tx_load |=> tx_pending)
        else $error("load did not set pending");
    a_write_fills:
        assert property ($rose(wr_n) && !cs_n && !port_select
                         |-> ##[2:6] rx_full)
        else $error("data write did not fill");
    a_ctrl_write:
        assert property ($rose(wr_n) && !cs_n && port_select
                         |-> ##[2:6] ctrl_strobe)
        else $error("control write not seen");
    a_strobe_single:
        assert property (ctrl_strobe |=> !ctrl_strobe)
        else $error("control pulse too long");
    a_idle_no_drive:
        assert property (cs_n[*5] |-> !host_byte_oe)
        else $error("bus driven without select");
endmodule
bind host_byte_port host_byte_port_monitor u_mon (.ref_clk, .sys_rst,
    .cs_n, .rd_n, .wr_n, .port_select, .host_byte_out, .host_byte_oe,
    .host_attention, .tx_load, .tx_pending, .rx_full, .ctrl_strobe);
`default_nettype wire

// ### bench/host_cpu_model.sv
// Behavioural host processor on the asynchronous byte bus.
// Assumes the bench calls its task; it steps on ref_clk edges.
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model (
    input  wire logic       ref_clk,       // stepping clock
    input  wire logic [7:0] host_byte_out, // device read data
    input  wire logic       host_byte_oe,  // device drives bus
    output logic            cs_n,          // chip select, low
    output logic            rd_n,          // read strobe, low
    output logic            wr_n,          // write strobe, low
    output logic            port_select,   // register choice
    output logic      [7:0] host_byte_in   // bus level at the pin
);
    logic [7:0] drv_q;
    logic       drv_on;
    initial begin
        {cs_n, rd_n, wr_n, port_select, drv_on} = 5'b11100;
        drv_q = 8'h00;
    end
    // Floating bus shows the inverse of the last value, never a hold
    assign host_byte_in = host_byte_oe ? host_byte_out
                        : (drv_on ? drv_q : ~drv_q);
    task automatic cycle(input logic en, sel, wr, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge ref_clk);
        cs_n <= !en;
        port_select <= sel;
        drv_q <= d;
        drv_on <= wr;
        @(posedge ref_clk);
        rd_n <= wr;
        wr_n <= !wr;
        repeat (7) @(posedge ref_clk);
        q = host_byte_in;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge ref_clk);
        cs_n <= 1'b1;
        port_select <= 1'b0;
        drv_on <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### bench/host_byte_port_bench.sv
// Self-checking bench for the host byte port with a host model.
// Assumes nothing outside this file set and the design package.
`timescale 1ns/1ns
`default_nettype none
module host_byte_port_bench;
    import host_port_pkg::*;
    logic       ref_clk = 0, sys_rst = 1, tx_load = 0, rx_ack = 0;
    logic [7:0] tx_byte = 8'h00, q, host_byte_in, host_byte_out;
    logic [7:0] rx_byte, ctrl_byte;
    logic       cs_n, rd_n, wr_n, port_select, host_byte_oe, rx_full;
    logic       host_attention, tx_pending, ctrl_strobe, write_overrun;
    logic [31:0] rng = 32'h7bc01e16;
    int pend = 0, full = 0, mismatches = 0, checks_done = 0, cycles = 0;
    int strobes = 0;
    host_byte_port u_host_byte_port (.ref_clk, .sys_rst, .cs_n, .rd_n,
        .wr_n, .port_select, .host_byte_in, .host_byte_out, .host_byte_oe,
        .host_attention, .tx_load, .tx_byte, .tx_pending, .rx_byte,
        .rx_full, .rx_ack, .ctrl_byte, .ctrl_strobe, .write_overrun);
    host_cpu_model u_host (.ref_clk, .host_byte_out, .host_byte_oe, .cs_n,
        .rd_n, .wr_n, .port_select, .host_byte_in);
    always #10 ref_clk = ~ref_clk;
    // Control pulses are counted away from the edge that launches them
    always @(negedge ref_clk) begin
        if (ctrl_strobe === 1'b1) begin
            strobes++;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] st();
        return {pend == 0, full != 0, 6'h00};
    endfunction
    task automatic chk(input logic [7:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        u_host.cycle(1, SEL_STATUS, 0, 8'h00, q);
        chk(q, st(), "reset status");
        for (int i = 0; i < 3; i++) begin
            repeat (130) @(posedge ref_clk);
            rng = xs(rng);
            tx_byte <= rng[7:0];
            tx_load <= 1'b1;
            @(posedge ref_clk);
            tx_load <= 1'b0;
            pend = 1;
            @(negedge ref_clk);
            chk(8'(host_attention), 8'(pend), "attention set");
            chk(8'(tx_pending), 8'(pend), "pending set");
            u_host.cycle(1, SEL_STATUS, 0, 8'h00, q);
            chk(q, st(), "status pending");
            u_host.cycle(1, SEL_DATA, 0, 8'h00, q);
            pend = 0;
            chk(q, rng[7:0], "read data");
            chk(8'(host_attention), 8'(pend), "attention clear");
            chk(8'(tx_pending), 8'(pend), "pending clear");
            u_host.cycle(1, SEL_DATA, 1, rng[15:8], q);
            full = 1;
            chk(rx_byte, rng[15:8], "inbound byte");
            u_host.cycle(1, SEL_STATUS, 0, 8'h00, q);
            chk(q, st(), "status full");
            @(posedge ref_clk);
            rx_ack <= 1'b1;
            @(posedge ref_clk);
            rx_ack <= 1'b0;
            full = 0;
            repeat (130) @(posedge ref_clk);
            u_host.cycle(1, SEL_STATUS, 1, rng[23:16], q);
            chk(8'(rx_full), 8'(full), "inbound freed");
            chk(ctrl_byte, rng[23:16], "control byte");
            chk(8'(strobes), 8'(i + 1), "control strobe");
            $display("round %0d done", i);
        end
        repeat (130) @(posedge ref_clk);
        u_host.cycle(0, SEL_DATA, 1, 8'h5a, q);
        chk(8'(rx_full), 8'(full), "write without select");
        chk(8'(write_overrun), 8'h00, "spaced writes");
        u_host.cycle(1, SEL_DATA, 1, 8'h3c, q);
        // One host cycle spans 14 edges, so write ends land exactly apart
        repeat (WRITE_CYC_TCK - 14) @(posedge ref_clk);
        u_host.cycle(1, SEL_DATA, 1, 8'h96, q);
        chk(8'(write_overrun), 8'h00, "writes at the limit");
        u_host.cycle(1, SEL_DATA, 1, 8'hc3, q);
        chk(8'(write_overrun), 8'h01, "close writes");
        chk(rx_byte, 8'hc3, "overwritten byte");
        $display("select and spacing tests done");
        close_out();
    end
endmodule
`default_nettype wire
